// ---- common/lps_defs.vh ----
`ifndef LPS_DEFS_VH
`define LPS_DEFS_VH

// register map, word addresses on the plain port
`define LPS_ADDR_W          4
`define LPS_A_CTRL          4'h0
`define LPS_A_STATUS        4'h1
`define LPS_A_RISE          4'h2
`define LPS_A_S2L           4'h3
`define LPS_A_L2B           4'h4
`define LPS_A_BL2L          4'h5
`define LPS_A_LOFF2P        4'h6
`define LPS_A_CYCLE         4'h7
`define LPS_A_LANE_OVR      4'h8

// control fields
`define LPS_CTRL_ON         0
`define LPS_CTRL_OVR_EN     1

// interval registers count milliseconds
`define LPS_IV_W            10
`define LPS_RISE_RST        10'h00A
`define LPS_S2L_RST         10'h032
`define LPS_L2B_RST         10'h0C8
`define LPS_BL2L_RST        10'h000
`define LPS_LOFF2P_RST      10'h032
`define LPS_CYCLE_RST       10'h190
`define LPS_LANES           5
`define LPS_LANE_OVR_RST    5'h00

// tick timing
`define LPS_CLK_HZ          10000000
`define LPS_TICK_US         1000

`endif

// ---- src/lps_ms_tick.v ----
`timescale 1ns/100ps
`include "lps_defs.vh"
module lps_ms_tick #(
	parameter CLK_HZ  = `LPS_CLK_HZ,
	parameter TICK_US = `LPS_TICK_US
) (
	input  wire sys_clk,
	input  wire rst,
	input  wire clk_en,
	output reg  tick_q
);
	localparam integer CYC = (CLK_HZ / 1000000) * TICK_US;
	localparam integer CW  = 14;
	localparam [31:0]   CYC_W = CYC;
	localparam [CW-1:0] LAST  = CYC_W[CW-1:0] - 1'b1;

	reg [CW-1:0] cnt_q;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q  <= {CW{1'b0}};
			tick_q <= 1'b0;
		end else if (clk_en) begin
			tick_q <= (cnt_q == LAST);
			if (cnt_q == LAST)
				cnt_q <= {CW{1'b0}};
			else
				cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // lps_ms_tick

// ---- src/lps_panel_seq.v ----
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "lps_defs.vh"

// Contract
// - separate panel supply and backlight supply enables, each timed alone
// - one sequencer owns supply, backlight and link activity
// - up: supply on, rise wait, link on after delay, backlight later
// - down: backlight off, link off after interval, then supply off
// - power-up waits until power-cycle delay since last power-off elapsed
// - sequencer may override lane power state during sequencing
module lps_panel_seq #(
	parameter CLK_HZ  = `LPS_CLK_HZ,
	parameter TICK_US = `LPS_TICK_US
) (
	input  wire                        sys_clk,
	input  wire                        rst,
	input  wire                        clk_en,
	input  wire [`LPS_ADDR_W-1:0]      reg_addr,
	input  wire [31:0]                 reg_wdata,
	input  wire                        reg_wr,
	input  wire                        reg_rd,
	output reg  [31:0]                 reg_rdata,
	output reg                         panel_supply_enable,
	output reg                         backlight_supply_enable,
	output reg                         link_active,
	output reg  [`LPS_LANES-1:0]       lane_power
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [2:0] S_OFF   = 3'h0;
	localparam [2:0] S_CYCLE = 3'h1;
	localparam [2:0] S_RISE  = 3'h2;
	localparam [2:0] S_S2L   = 3'h3;
	localparam [2:0] S_L2B   = 3'h4;
	localparam [2:0] S_ON    = 3'h5;
	localparam [2:0] S_BL2L  = 3'h6;
	localparam [2:0] S_LOFF  = 3'h7;

	reg                      on_req_q;
	reg                      ovr_en_q;
	reg [`LPS_IV_W-1:0]      rise_q;
	reg [`LPS_IV_W-1:0]      s2l_q;
	reg [`LPS_IV_W-1:0]      l2b_q;
	reg [`LPS_IV_W-1:0]      bl2l_q;
	reg [`LPS_IV_W-1:0]      loff_q;
	reg [`LPS_IV_W-1:0]      cycle_q;
	reg [`LPS_LANES-1:0]     lane_sel_q;
	reg [2:0]                st_q;
	reg [2:0]                st_d;
	reg [`LPS_IV_W-1:0]      cnt_q;
	reg [`LPS_IV_W-1:0]      lim;
	reg                      cycle_done_q;
	wire                     tick;
	wire                     wr_en;
	wire                     rd_en;
	wire                     link_d;

	assign wr_en = clk_en & reg_wr;
	assign rd_en = clk_en & reg_rd;
	// link state of the next cycle, shared by link and lane outputs
	assign link_d = (st_d == S_L2B) || (st_d == S_ON) ||
		(st_d == S_BL2L);

	// ------------------------------------------------------------
	// millisecond tick
	// ------------------------------------------------------------
	lps_ms_tick #(
		.CLK_HZ  (CLK_HZ),
		.TICK_US (TICK_US)
	) u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.tick_q  (tick)
	);

	function in_seq;
		input [2:0] s;
		begin
			in_seq = (s != S_OFF) && (s != S_ON) && (s != S_CYCLE);
		end
	endfunction

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			on_req_q   <= 1'b0;
			ovr_en_q   <= 1'b0;
			rise_q     <= `LPS_RISE_RST;
			s2l_q      <= `LPS_S2L_RST;
			l2b_q      <= `LPS_L2B_RST;
			bl2l_q     <= `LPS_BL2L_RST;
			loff_q     <= `LPS_LOFF2P_RST;
			cycle_q    <= `LPS_CYCLE_RST;
			lane_sel_q <= `LPS_LANE_OVR_RST;
		end else if (wr_en) begin
			case (reg_addr)
			`LPS_A_CTRL: begin
				on_req_q <= reg_wdata[`LPS_CTRL_ON];
				ovr_en_q <= reg_wdata[`LPS_CTRL_OVR_EN];
			end
			`LPS_A_RISE:     rise_q     <= reg_wdata[`LPS_IV_W-1:0];
			`LPS_A_S2L:      s2l_q      <= reg_wdata[`LPS_IV_W-1:0];
			`LPS_A_L2B:      l2b_q      <= reg_wdata[`LPS_IV_W-1:0];
			`LPS_A_BL2L:     bl2l_q     <= reg_wdata[`LPS_IV_W-1:0];
			`LPS_A_LOFF2P:   loff_q     <= reg_wdata[`LPS_IV_W-1:0];
			`LPS_A_CYCLE:    cycle_q    <= reg_wdata[`LPS_IV_W-1:0];
			`LPS_A_LANE_OVR: lane_sel_q <= reg_wdata[`LPS_LANES-1:0];
			default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// register reads, data valid the cycle after the strobe
	// ------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (clk_en) begin
			reg_rdata <= 32'h00000000;
			if (rd_en) begin
				case (reg_addr)
				`LPS_A_CTRL:     reg_rdata <= {30'h0, ovr_en_q, on_req_q};
				`LPS_A_STATUS:   reg_rdata <= {25'h0, cycle_done_q,
					link_active, backlight_supply_enable,
					panel_supply_enable, st_q};
				`LPS_A_RISE:     reg_rdata <= {22'h0, rise_q};
				`LPS_A_S2L:      reg_rdata <= {22'h0, s2l_q};
				`LPS_A_L2B:      reg_rdata <= {22'h0, l2b_q};
				`LPS_A_BL2L:     reg_rdata <= {22'h0, bl2l_q};
				`LPS_A_LOFF2P:   reg_rdata <= {22'h0, loff_q};
				`LPS_A_CYCLE:    reg_rdata <= {22'h0, cycle_q};
				`LPS_A_LANE_OVR: reg_rdata <= {27'h0, lane_sel_q};
				default:         reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always @* begin
		case (st_q)
		S_CYCLE: lim = cycle_q;
		S_RISE:  lim = rise_q;
		S_S2L:   lim = s2l_q;
		S_L2B:   lim = l2b_q;
		S_BL2L:  lim = bl2l_q;
		S_LOFF:  lim = loff_q;
		default: lim = {`LPS_IV_W{1'b0}};
		endcase
	end

	always @* begin
		st_d = st_q;
		case (st_q)
		S_OFF:   if (on_req_q && cycle_done_q) st_d = S_RISE;
		S_CYCLE: if (cnt_q >= lim) st_d = S_OFF;
		S_RISE:  if (!on_req_q) st_d = S_LOFF;
			else if (cnt_q >= lim) st_d = S_S2L;
		S_S2L:   if (!on_req_q) st_d = S_LOFF;
			else if (cnt_q >= lim) st_d = S_L2B;
		S_L2B:   if (!on_req_q) st_d = S_BL2L;
			else if (cnt_q >= lim) st_d = S_ON;
		S_ON:    if (!on_req_q) st_d = S_BL2L;
		S_BL2L:  if (cnt_q >= lim) st_d = S_LOFF;
		S_LOFF:  if (cnt_q >= lim) st_d = S_CYCLE;
		default: st_d = S_OFF;
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q                    <= S_OFF;
			cnt_q                   <= {`LPS_IV_W{1'b0}};
			cycle_done_q            <= 1'b1;
			panel_supply_enable     <= 1'b0;
			backlight_supply_enable <= 1'b0;
			link_active             <= 1'b0;
			lane_power              <= {`LPS_LANES{1'b0}};
		end else if (clk_en) begin
			st_q <= st_d;
			if (st_d != st_q)
				cnt_q <= {`LPS_IV_W{1'b0}};
			else if (tick && cnt_q < lim)
				cnt_q <= cnt_q + 1'b1;
			if (st_d == S_CYCLE)
				cycle_done_q <= 1'b0;
			else if (st_q == S_CYCLE && st_d == S_OFF)
				cycle_done_q <= 1'b1;
			// outputs derived from the next state, one owner
			panel_supply_enable <= (st_d != S_OFF) &&
				(st_d != S_CYCLE);
			backlight_supply_enable <= (st_d == S_ON);
			link_active <= link_d;
			if (ovr_en_q && in_seq(st_d))
				lane_power <= {`LPS_LANES{1'b0}};
			else if (link_d)
				lane_power <= ~lane_sel_q;
			else
				lane_power <= {`LPS_LANES{1'b0}};
		end
	end
endmodule // lps_panel_seq

// ---- verif/lps_panel_model.sv ----
`timescale 1ns/100ps
// ----------------
// panel and backlight supply
// ----------------
module lps_panel_model (
	input  wire sys_clk,
	input  wire rst,
	input  wire panel_supply_enable,
	input  wire backlight_supply_enable,
	input  wire link_active,
	output logic seq_bad
);
	// latches link active without supply, or backlight on without link
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			seq_bad <= 1'b0;
		else if (link_active && !panel_supply_enable)
			seq_bad <= 1'b1;
		else if (backlight_supply_enable && !link_active)
			seq_bad <= 1'b1;
	end
endmodule // lps_panel_model

// ---- verif/lps_seq_asserts.sv ----
`timescale 1ns/100ps
`include "lps_defs.vh"
module lps_seq_asserts (
	input wire                   sys_clk,
	input wire                   rst,
	input wire                   clk_en,
	input wire [`LPS_ADDR_W-1:0] reg_addr,
	input wire [31:0]            reg_wdata,
	input wire                   reg_wr,
	input wire                   reg_rd,
	input wire [31:0]            reg_rdata,
	input wire                   panel_supply_enable,
	input wire                   backlight_supply_enable,
	input wire                   link_active,
	input wire [`LPS_LANES-1:0]  lane_power
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_bl_needs_link: assert property (
		backlight_supply_enable |-> link_active)
		else $error("backlight on without link");
	a_link_needs_vdd: assert property (
		link_active |-> panel_supply_enable)
		else $error("link active without supply");
	a_vdd_rise_first: assert property (
		$rose(panel_supply_enable) |-> !link_active)
		else $error("supply rose late");
	a_bl_rise_late: assert property (
		$rose(backlight_supply_enable) |-> $past(link_active, 2))
		else $error("backlight rose with link");
	a_vdd_fall_last: assert property (
		$fell(panel_supply_enable) |->
		!link_active && !backlight_supply_enable)
		else $error("supply fell too early");
	a_rdata_idle: assert property (
		$past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	a_lanes_dark: assert property (
		!link_active |-> lane_power == 5'h00)
		else $error("lanes powered without link");
	a_freeze_hold: assert property (
		!clk_en |=> $stable({panel_supply_enable, link_active,
		backlight_supply_enable}))
		else $error("outputs moved while frozen");
endmodule // lps_seq_asserts
bind lps_panel_seq lps_seq_asserts i_chk (.sys_clk(sys_clk), .rst(rst),
	.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.panel_supply_enable(panel_supply_enable),
	.backlight_supply_enable(backlight_supply_enable),
	.link_active(link_active), .lane_power(lane_power));

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`include "lps_defs.vh"
module tb;
	logic                   sys_clk = 0;
	logic                   rst = 1;
	logic                   clk_en = 1;
	logic [`LPS_ADDR_W-1:0] reg_addr = 4'h0;
	logic [31:0]            reg_wdata = 32'h0;
	logic                   reg_wr = 0;
	logic                   reg_rd = 0;
	wire  [31:0]            reg_rdata;
	wire                    pse, bse, lnk, bad;
	wire  [4:0]             lanes;
	int err_total = 0;
	int num_checks = 0;
	int iv[6];
	int lo[6] = '{1, 1, 3, 0, 1, 4};
	int dflt[7] = '{10, 50, 200, 0, 50, 400, 0};
	always #50 sys_clk = ~sys_clk;
	lps_panel_seq #(.TICK_US(1)) i_dut (.sys_clk(sys_clk), .rst(rst),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.panel_supply_enable(pse), .backlight_supply_enable(bse),
		.link_active(lnk), .lane_power(lanes));
	lps_panel_model i_panel (.sys_clk(sys_clk), .rst(rst),
		.panel_supply_enable(pse), .backlight_supply_enable(bse),
		.link_active(lnk), .seq_bad(bad));
	// ----------------
	// bus and checks
	// ----------------
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(string n, logic [31:0] e, logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task wr(int a, int d);
		@(posedge sys_clk);
		reg_addr <= a[3:0];
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask
	task rchk(int a, int e);
		@(posedge sys_clk);
		reg_addr <= a[3:0];
		reg_rd <= 1;
		@(posedge sys_clk);
		reg_rd <= 0;
		#10 chk("rdata", e, reg_rdata);
	endtask
	// cycles until output sel reaches v, bounded
	function logic outv(int sel);
		case (sel)
		0: return pse;
		1: return lnk;
		default: return bse;
		endcase
	endfunction
	task wt(int sel, logic v, output int n);
		n = 0;
		while (outv(sel) !== v) begin
			@(posedge sys_clk);
			#1 n++;
			if (n > 200) begin
				err_total++;
				report_and_stop;
			end
		end
	endtask
	function logic [31:0] inr(int n, int t);
		return n >= t * 10 - 10 && n <= t * 10 + 25;
	endfunction
	// ----------------
	// sequence
	// ----------------
	initial begin
		int n, m;
		void'($urandom(58));
		repeat (8) @(posedge sys_clk);
		rst <= 0;
		rchk(1, 32'h40);
		rchk(15, 0);
		for (int i = 0; i < 7; i++) rchk(i + 2, dflt[i]);
		for (int i = 0; i < 6; i++) begin
			iv[i] = lo[i] + $urandom % 3;
			wr(i + 2, iv[i]);
			rchk(i + 2, iv[i]);
		end
		// mask never all ones, so powered lanes differ from zero
		m = $urandom % 31;
		wr(8, m);
		wr(0, 1);
		wt(0, 1, n);
		chk("vdd_on", 1, n <= 3);
		wt(1, 1, n);
		chk("t_link", 1, inr(n, iv[0] + iv[1]));
		// freeze mid-sequence: the wait must stretch by the frozen span
		@(posedge sys_clk);
		clk_en <= 0;
		repeat (30) @(posedge sys_clk);
		clk_en <= 1;
		wt(2, 1, n);
		chk("t_bl", 1, inr(n + 1, iv[2]));
		#10 chk("lanes", ~m & 5'h1F, lanes);
		wr(0, 0);
		wt(2, 0, n);
		chk("bl_off", 1, n <= 3);
		wt(1, 0, n);
		chk("t_loff", 1, inr(n, iv[3]));
		wt(0, 0, n);
		chk("t_pwroff", 1, inr(n, iv[4]));
		wr(0, 3);
		wt(0, 1, n);
		chk("t_cycle", 1, inr(n + 2, iv[5]));
		wt(1, 1, n);
		#10 chk("lanes_ovr", 0, lanes);
		chk("order", 0, bad);
		@(posedge sys_clk);
		rst <= 1;
		#200 chk("rst_vdd", 0, pse);
		@(posedge sys_clk);
		rst <= 0;
		rchk(1, 32'h40);
		report_and_stop;
	end
endmodule // tb
